// ==== hw/iit_issue_interlock.sv ====
`timescale 1ns/1ps
`default_nettype none

module iit_issue_interlock (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Decode side
  input wire logic in_valid,
  input wire iit_pkg::iit_desc_t in_desc,
  output logic in_ready,
  // Issue result
  output iit_pkg::iit_issue_t issue_out
);

  // ****************************************
  // Operand roles
  // ****************************************
  // Slot 0 first source, 1 shifted source, 2 shift distance, 3 accumulator
  function automatic iit_pkg::iit_role_t role_of(input iit_pkg::iit_op_t op,
                                                  input logic [1:0] slot);
    role_of = iit_pkg::IIT_ROLE_NORMAL;
    case (op)
      iit_pkg::IIT_OP_WORD_LOAD: begin
        if (slot == 2'h0) role_of = iit_pkg::IIT_ROLE_EARLY;
      end
      iit_pkg::IIT_OP_DP_IMM_SHIFT: begin
        if (slot == 2'h1) role_of = iit_pkg::IIT_ROLE_EARLY;
      end
      iit_pkg::IIT_OP_DP_REG_SHIFT: begin
        if (slot == 2'h2) role_of = iit_pkg::IIT_ROLE_EARLY;
        if (slot == 2'h0) role_of = iit_pkg::IIT_ROLE_LATE;
      end
      iit_pkg::IIT_OP_DSAT: begin
        if (slot == 2'h0) role_of = iit_pkg::IIT_ROLE_EARLY;
      end
      iit_pkg::IIT_OP_MEDIA_SHIFT_ALU, iit_pkg::IIT_OP_MEDIA_SHIFT_SAT: begin
        if (slot == 2'h1) role_of = iit_pkg::IIT_ROLE_EARLY;
      end
      iit_pkg::IIT_OP_SAD, iit_pkg::IIT_OP_SAD_ACC: begin
        if (slot == 2'h1 || slot == 2'h2) role_of = iit_pkg::IIT_ROLE_EARLY;
        if (slot == 2'h3) role_of = iit_pkg::IIT_ROLE_ACCUM;
      end
      default: role_of = iit_pkg::IIT_ROLE_NORMAL;
    endcase
  endfunction

  // Counter holds latency at first cycle after issue and counts down
  function automatic logic role_ok(input iit_pkg::iit_role_t role, input logic [3:0] cnt,
                                   input logic sad);
    case (role)
      iit_pkg::IIT_ROLE_EARLY: role_ok = (cnt <= iit_pkg::READY_EARLY);
      iit_pkg::IIT_ROLE_LATE: role_ok = (cnt <= iit_pkg::READY_LATE);
      iit_pkg::IIT_ROLE_ACCUM: begin
        role_ok = sad ? (cnt <= iit_pkg::READY_ACCUM_SAD) : (cnt <= iit_pkg::READY_NORMAL);
      end
      iit_pkg::IIT_ROLE_NONE: role_ok = 1'b1;
      default: role_ok = (cnt <= iit_pkg::READY_NORMAL);
    endcase
  endfunction

  function automatic logic operand_ok(input iit_pkg::iit_operand_t opd,
                                      input iit_pkg::iit_role_t role,
                                      input iit_pkg::iit_state_t st);
    // Program counter reads never stall
    if (!opd.valid || opd.idx == iit_pkg::PC_REG) operand_ok = 1'b1;
    else operand_ok = role_ok(role, st.sb_cnt[opd.idx], st.sb_sad[opd.idx]);
  endfunction

  function automatic logic sources_ok(input iit_pkg::iit_desc_t d,
                                      input iit_pkg::iit_state_t st);
    sources_ok = operand_ok(d.rn, role_of(d.op, 2'h0), st) &&
                 operand_ok(d.rm, role_of(d.op, 2'h1), st) &&
                 operand_ok(d.rs, role_of(d.op, 2'h2), st) &&
                 operand_ok(d.ra, role_of(d.op, 2'h3), st);
  endfunction

  // ****************************************
  // Latency and cycle count
  // ****************************************
  function automatic logic [3:0] latency_of(input iit_pkg::iit_op_t op);
    case (op)
      iit_pkg::IIT_OP_WORD_LOAD: latency_of = iit_pkg::LAT_LOAD;
      iit_pkg::IIT_OP_DP_REG_SHIFT: latency_of = iit_pkg::LAT_REG_SHIFT;
      iit_pkg::IIT_OP_SAT, iit_pkg::IIT_OP_DSAT: latency_of = iit_pkg::LAT_SAT;
      iit_pkg::IIT_OP_MEDIA_SAT, iit_pkg::IIT_OP_MEDIA_SHIFT_SAT: begin
        latency_of = iit_pkg::LAT_SAT;
      end
      iit_pkg::IIT_OP_SAD, iit_pkg::IIT_OP_SAD_ACC: latency_of = iit_pkg::LAT_SAD;
      default: latency_of = iit_pkg::LAT_ALU;
    endcase
  endfunction

  function automatic logic [3:0] cond_cycles(input logic [3:0] mn, input logic [3:0] mx,
                                             input logic [3:0] gap);
    // Saturating subtract keeps a large gap from wrapping below the minimum
    if (gap >= mx) cond_cycles = mn;
    else if (mx - gap > mn) cond_cycles = mx - gap;
    else cond_cycles = mn;
  endfunction

  function automatic logic is_dp(input iit_pkg::iit_op_t op);
    is_dp = (op == iit_pkg::IIT_OP_DP) || (op == iit_pkg::IIT_OP_DP_IMM_SHIFT) ||
            (op == iit_pkg::IIT_OP_DP_REG_SHIFT);
  endfunction

  function automatic logic [3:0] cycles_of(input iit_pkg::iit_desc_t d, input logic [3:0] gap);
    logic [3:0] base;
    logic [3:0] mn;
    logic [3:0] mx;
    base = (d.op == iit_pkg::IIT_OP_DP_REG_SHIFT) ? iit_pkg::CYC_TWO : iit_pkg::CYC_ONE;
    mn = iit_pkg::CYC_PC_OTHER;
    mx = iit_pkg::CYC_PC_OTHER;
    if (!d.pc_dest || !is_dp(d.op)) begin
      cycles_of = base;
    end else if (d.cond && !d.cond_pass) begin
      cycles_of = base;
    end else if (d.is_move && d.link_src && !d.cond && d.stack != iit_pkg::IIT_STACK_EMPTY) begin
      cycles_of = (d.stack == iit_pkg::IIT_STACK_HIT) ? iit_pkg::CYC_LINK_HIT :
                  iit_pkg::CYC_LINK_MISS;
    end else begin
      if (d.is_move && d.link_src) begin
        mn = iit_pkg::CYC_LINK_MIN;
        mx = iit_pkg::CYC_LINK_MAX;
      end else if (d.is_move) begin
        case (d.op)
          iit_pkg::IIT_OP_DP_IMM_SHIFT: begin
            mn = iit_pkg::CYC_MOV_IMM;
            mx = iit_pkg::CYC_MOV_IMM_MAX;
          end
          iit_pkg::IIT_OP_DP_REG_SHIFT: begin
            mn = iit_pkg::CYC_MOV_REG;
            mx = iit_pkg::CYC_MOV_REG;
          end
          default: begin
            mn = iit_pkg::CYC_MOV_PLAIN;
            mx = iit_pkg::CYC_MOV_PLAIN_MAX;
          end
        endcase
      end else if (d.op == iit_pkg::IIT_OP_DP_REG_SHIFT) begin
        mn = iit_pkg::CYC_PC_OTHER_REG;
        mx = iit_pkg::CYC_PC_OTHER_REG;
      end
      cycles_of = d.cond ? cond_cycles(mn, mx, gap) : mn;
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  iit_pkg::iit_state_t st_r;
  iit_pkg::iit_state_t st_nxt;
  logic fire;
  logic [3:0] cyc_now;

  assign in_ready = (st_r.busy == 4'h0) && sources_ok(in_desc, st_r);
  assign fire = in_valid && in_ready;
  assign cyc_now = cycles_of(in_desc, st_r.gap);
  assign issue_out = st_r.res;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < iit_pkg::REG_COUNT; i++) begin
      if (st_r.sb_cnt[i] != iit_pkg::CNT_RST) st_nxt.sb_cnt[i] = st_r.sb_cnt[i] - 4'h1;
    end
    // Stall cycles still drain the scoreboard, so independent ops fill the slots
    if (fire && in_desc.dest_we && !in_desc.pc_dest && in_desc.dest != iit_pkg::PC_REG) begin
      st_nxt.sb_cnt[in_desc.dest] = latency_of(in_desc.op);
      st_nxt.sb_sad[in_desc.dest] = (in_desc.op == iit_pkg::IIT_OP_SAD) ||
                                    (in_desc.op == iit_pkg::IIT_OP_SAD_ACC);
    end
    if (fire) st_nxt.busy = cyc_now - 4'h1;
    else if (st_r.busy != 4'h0) st_nxt.busy = st_r.busy - 4'h1;
    // Gap holds while the setter still occupies issue
    if (fire && in_desc.sets_flags) st_nxt.gap = 4'h0;
    else if (st_r.busy == 4'h0 && st_r.gap != iit_pkg::GAP_MAX) st_nxt.gap = st_r.gap + 4'h1;
    st_nxt.res.fire = fire;
    if (fire) begin
      st_nxt.res.cycles = cyc_now;
      st_nxt.res.latency = latency_of(in_desc.op);
      st_nxt.res.dest_we = in_desc.dest_we && !in_desc.pc_dest;
      st_nxt.res.dest = in_desc.dest;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.gap <= iit_pkg::GAP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic res_dep;
  logic in_load;
  logic in_plain_pc_mov;

  // Reader of the last issued destination needing it at normal stage or earlier
  always_comb begin
    res_dep = 1'b0;
    if (in_desc.rn.valid && in_desc.rn.idx == st_r.res.dest &&
        role_of(in_desc.op, 2'h0) != iit_pkg::IIT_ROLE_LATE) res_dep = 1'b1;
    if (in_desc.rm.valid && in_desc.rm.idx == st_r.res.dest) res_dep = 1'b1;
    if (in_desc.rs.valid && in_desc.rs.idx == st_r.res.dest) res_dep = 1'b1;
    if (in_desc.ra.valid && in_desc.ra.idx == st_r.res.dest) res_dep = 1'b1;
  end

  assign in_load = in_desc.op == iit_pkg::IIT_OP_WORD_LOAD;
  assign in_plain_pc_mov = in_desc.pc_dest && in_desc.is_move && !in_desc.link_src &&
                           !in_desc.cond && in_desc.op == iit_pkg::IIT_OP_DP;

  a_load_latency: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_load && in_desc.dest_we && in_desc.dest != iit_pkg::PC_REG |=>
    st_r.sb_cnt[st_r.res.dest] == 4'h3 && st_r.res.cycles == 4'h1)
    else $error("word load latency or cycles wrong");

  // A take in between moves the last result away from the load
  a_load_use_stall: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_load && in_desc.dest_we && in_desc.dest != iit_pkg::PC_REG |=>
    !(fire && res_dep) ##1 !(fire && res_dep && !st_r.res.fire))
    else $error("consumer issued inside load latency");

  a_add_feeds_base: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.op == iit_pkg::IIT_OP_DP && in_desc.dest_we && !in_desc.pc_dest &&
    in_desc.dest != iit_pkg::PC_REG |=>
    !(fire && in_load && in_desc.rn.valid && in_desc.rn.idx == st_r.res.dest))
    else $error("load base issued one cycle after its producer");

  a_add_back_to_back: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.op == iit_pkg::IIT_OP_DP && !in_desc.pc_dest |=>
    st_r.res.cycles == 4'h1 && st_r.busy == 4'h0 &&
    (!(in_valid && in_desc.op == iit_pkg::IIT_OP_DP && in_desc.rn.valid &&
       in_desc.rn.idx == st_r.res.dest && st_r.res.dest_we && !in_desc.rm.valid &&
       !in_desc.rs.valid && !in_desc.ra.valid) || in_ready))
    else $error("plain add did not allow back to back issue");

  a_reg_shift_two: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.op == iit_pkg::IIT_OP_DP_REG_SHIFT && !in_desc.pc_dest |=>
    !in_ready ##1 st_r.busy == 4'h0)
    else $error("register shift did not hold issue for two cycles");

  a_link_return: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.pc_dest && in_desc.is_move && in_desc.link_src && !in_desc.cond &&
    in_desc.op == iit_pkg::IIT_OP_DP && in_desc.stack != iit_pkg::IIT_STACK_EMPTY |=>
    st_r.res.cycles == ($past(in_desc.stack) == iit_pkg::IIT_STACK_HIT ? 4'h4 : 4'h7))
    else $error("link return cycle count wrong");

  a_pc_move_plain: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_plain_pc_mov |=> st_r.res.cycles == 4'h5 ##1 !in_ready [*3])
    else $error("plain move to PC cycle count wrong");

  a_pc_other_cycles: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.pc_dest && !in_desc.is_move && !in_desc.cond &&
    in_desc.op == iit_pkg::IIT_OP_DP_REG_SHIFT |=> st_r.res.cycles == 4'h8)
    else $error("register shift PC write cycle count wrong");

  a_pc_move_shift: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.pc_dest && in_desc.is_move && !in_desc.link_src && !in_desc.cond &&
    in_desc.op == iit_pkg::IIT_OP_DP_IMM_SHIFT |=> st_r.res.cycles == 4'h6)
    else $error("shifted move to PC cycle count wrong");

  a_flag_gap_start: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.sets_flags |=> st_r.gap == 4'h0)
    else $error("flag gap not restarted by setter");

  a_cond_pass_bounds: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.pc_dest && in_desc.is_move && !in_desc.link_src && in_desc.cond &&
    in_desc.cond_pass && in_desc.op == iit_pkg::IIT_OP_DP |=>
    st_r.res.cycles >= 4'h5 && st_r.res.cycles <= 4'h7 &&
    ($past(st_r.gap) != 4'h0 || st_r.res.cycles == 4'h7))
    else $error("conditional PC write out of range");

  a_cond_fail_cycles: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.pc_dest && in_desc.cond && !in_desc.cond_pass && is_dp(in_desc.op) |=>
    st_r.res.cycles <= 4'h2)
    else $error("failing PC write not at ordinary count");

  a_sat_latency: assert property (@(posedge core_clk) disable iff (rst)
    fire && (in_desc.op == iit_pkg::IIT_OP_SAT || in_desc.op == iit_pkg::IIT_OP_DSAT) |=>
    st_r.res.latency == 4'h2 && st_r.res.cycles == 4'h1)
    else $error("saturating op latency wrong");

  a_sad_latency: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.op == iit_pkg::IIT_OP_SAD |=> st_r.res.latency == 4'h3)
    else $error("absolute difference sum latency wrong");

  // The accumulator shortcut depends on this mark surviving the countdown
  a_sad_scoreboard: assert property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.op == iit_pkg::IIT_OP_SAD && in_desc.dest_we && !in_desc.pc_dest &&
    in_desc.dest != iit_pkg::PC_REG |=>
    st_r.sb_sad[st_r.res.dest] && st_r.sb_cnt[st_r.res.dest] == 4'h3)
    else $error("absolute difference sum not marked in scoreboard");

  a_busy_blocks: assert property (@(posedge core_clk) disable iff (rst)
    st_r.busy != 4'h0 |-> !in_ready ##1 st_r.busy == $past(st_r.busy) - 4'h1)
    else $error("issue accepted while busy");

  c_load_use: cover property (@(posedge core_clk) disable iff (rst)
    fire && in_load ##1 (in_valid && res_dep && !in_ready) [*2] ##1 fire);

  c_sad_to_acc: cover property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.op == iit_pkg::IIT_OP_SAD ##2 fire && in_desc.op == iit_pkg::IIT_OP_SAD_ACC);

  c_link_miss: cover property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.link_src && in_desc.stack == iit_pkg::IIT_STACK_MISS);

  c_cond_pc: cover property (@(posedge core_clk) disable iff (rst)
    fire && in_desc.pc_dest && in_desc.cond && in_desc.cond_pass);

  c_load_late: cover property (@(posedge core_clk) disable iff (rst)
    fire && in_load ##2 fire && in_desc.op == iit_pkg::IIT_OP_DP_REG_SHIFT);

endmodule

`default_nettype wire

// ==== shared/iit_pkg.sv ====
package iit_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned REG_COUNT = 16;
  localparam int unsigned REG_W = 4;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned CYC_W = 4;
  localparam logic [3:0] PC_REG = 4'hf;

  // ****************************************
  // Result latencies, counted from the first issue cycle
  // ****************************************
  localparam logic [3:0] LAT_ALU = 4'h1;
  localparam logic [3:0] LAT_REG_SHIFT = 4'h2;
  localparam logic [3:0] LAT_LOAD = 4'h3;
  localparam logic [3:0] LAT_SAT = 4'h2;
  localparam logic [3:0] LAT_SAD = 4'h3;

  // ****************************************
  // Issue cycle counts
  // ****************************************
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_LINK_HIT = 4'h4;
  localparam logic [3:0] CYC_LINK_MISS = 4'h7;
  localparam logic [3:0] CYC_LINK_MIN = 4'h5;
  localparam logic [3:0] CYC_LINK_MAX = 4'h7;
  localparam logic [3:0] CYC_MOV_PLAIN = 4'h5;
  localparam logic [3:0] CYC_MOV_PLAIN_MAX = 4'h7;
  localparam logic [3:0] CYC_MOV_IMM = 4'h6;
  localparam logic [3:0] CYC_MOV_IMM_MAX = 4'h7;
  localparam logic [3:0] CYC_MOV_REG = 4'h7;
  localparam logic [3:0] CYC_PC_OTHER = 4'h7;
  localparam logic [3:0] CYC_PC_OTHER_REG = 4'h8;

  // ****************************************
  // Scoreboard thresholds and reset values
  // ****************************************
  localparam logic [3:0] READY_EARLY = 4'h0;
  localparam logic [3:0] READY_NORMAL = 4'h1;
  localparam logic [3:0] READY_LATE = 4'h2;
  localparam logic [3:0] READY_ACCUM_SAD = 4'h2;
  localparam logic [3:0] GAP_MAX = 4'hf;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] GAP_RST = 4'hf;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    IIT_OP_DP, IIT_OP_DP_IMM_SHIFT, IIT_OP_DP_REG_SHIFT, IIT_OP_WORD_LOAD,
    IIT_OP_SAT, IIT_OP_DSAT, IIT_OP_MEDIA_ALU, IIT_OP_MEDIA_SAT,
    IIT_OP_MEDIA_SHIFT_ALU, IIT_OP_MEDIA_SHIFT_SAT, IIT_OP_SAD, IIT_OP_SAD_ACC
  } iit_op_t;

  typedef enum logic [1:0] {IIT_STACK_HIT, IIT_STACK_MISS, IIT_STACK_EMPTY} iit_stack_t;

  typedef enum logic [2:0] {
    IIT_ROLE_NONE, IIT_ROLE_EARLY, IIT_ROLE_NORMAL, IIT_ROLE_LATE, IIT_ROLE_ACCUM
  } iit_role_t;

  typedef struct packed {
    logic valid;
    logic [3:0] idx;
  } iit_operand_t;

  typedef struct packed {
    iit_op_t op;
    logic pc_dest;
    logic is_move;
    logic link_src;
    logic cond;
    logic cond_pass;
    logic sets_flags;
    iit_stack_t stack;
    logic dest_we;
    logic [3:0] dest;
    iit_operand_t rn;
    iit_operand_t rm;
    iit_operand_t rs;
    iit_operand_t ra;
  } iit_desc_t;

  typedef struct packed {
    logic fire;
    logic [3:0] cycles;
    logic [3:0] latency;
    logic dest_we;
    logic [3:0] dest;
  } iit_issue_t;

  typedef struct packed {
    logic [15:0][3:0] sb_cnt;
    logic [15:0] sb_sad;
    logic [3:0] busy;
    logic [3:0] gap;
    iit_issue_t res;
  } iit_state_t;

endpackage

// ==== tb/iit_decode_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module iit_decode_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Issue side
  input wire logic in_ready,
  input wire iit_pkg::iit_issue_t issue_out,
  output logic in_valid,
  output iit_pkg::iit_desc_t in_desc
);
  iit_pkg::iit_desc_t q[$];
  int takes[$];
  iit_pkg::iit_issue_t res[$];
  int cyc;

  function automatic void clear();
    q.delete();
    takes.delete();
    res.delete();
  endfunction

  // Scenarios never queue a zero-count into the PC
  function automatic void push(iit_pkg::iit_desc_t d);
    q.push_back(d);
  endfunction

  initial begin
    in_valid = 1'b0;
    in_desc = '0;
    cyc = 0;
  end

  // ****************************************
  // Present, hold until taken, then next
  // ****************************************
  // Idle descriptor flips every cycle so nothing leans on stale fields
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (rst) begin
      in_valid <= 1'b0;
    end else begin
      if (issue_out.fire === 1'b1) res.push_back(issue_out);
      if (in_valid && in_ready === 1'b1) begin
        takes.push_back(cyc);
        void'(q.pop_front());
      end
      in_valid <= (q.size() != 0);
      in_desc <= (q.size() != 0) ? q[0] : iit_pkg::iit_desc_t'(~in_desc);
    end
  end
endmodule

`default_nettype wire

// ==== tb/iit_issue_interlock_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module iit_issue_interlock_tb;
  logic core_clk;
  logic rst;
  logic in_valid;
  iit_pkg::iit_desc_t in_desc;
  logic in_ready;
  iit_pkg::iit_issue_t issue_out;
  int num_errors;
  int num_checks;
  int cycle_count;
  iit_pkg::iit_desc_t ld;
  iit_pkg::iit_desc_t ad;
  iit_pkg::iit_desc_t ia;

  iit_issue_interlock dut (.core_clk(core_clk), .rst(rst), .in_valid(in_valid),
    .in_desc(in_desc), .in_ready(in_ready), .issue_out(issue_out));
  iit_decode_model dec (.core_clk(core_clk), .rst(rst), .in_ready(in_ready),
    .issue_out(issue_out), .in_valid(in_valid), .in_desc(in_desc));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycle_count++;
    if (cycle_count == 6000) begin
      num_errors++;
      end_sim();
    end
  end

  // Register index 0 stands for an unused slot
  function automatic iit_pkg::iit_desc_t mk(iit_pkg::iit_op_t op, logic [3:0] d,
      logic [3:0] n, logic [3:0] m, logic [3:0] s);
    iit_pkg::iit_desc_t r;
    r = '0;
    r.op = op;
    r.dest_we = (d != 4'h0);
    r.dest = d;
    r.rn = '{n != 4'h0, n};
    r.rm = '{m != 4'h0, m};
    r.rs = '{s != 4'h0, s};
    return r;
  endfunction

  function automatic iit_pkg::iit_desc_t mkpc(iit_pkg::iit_op_t op, logic mv, logic lk,
      iit_pkg::iit_stack_t st, logic c, logic p);
    iit_pkg::iit_desc_t r;
    r = mk(op, 4'hf, 4'h5, 4'h0, 4'h0);
    r.pc_dest = 1'b1;
    r.is_move = mv;
    r.link_src = lk;
    r.stack = st;
    r.cond = c;
    r.cond_pass = p;
    return r;
  endfunction

  // Drain of 12 cycles covers the longest busy plus latency
  task automatic play(input iit_pkg::iit_desc_t d[$]);
    int n;
    n = 0;
    dec.clear();
    foreach (d[i]) dec.push(d[i]);
    while (dec.takes.size() < d.size() && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 100) check(0, 1, "take timeout");
    repeat (12) @(posedge core_clk);
  endtask

  task automatic pair(input iit_pkg::iit_desc_t a, input iit_pkg::iit_desc_t b,
      input int gap, input string what);
    play('{a, b});
    check(dec.takes[1] - dec.takes[0], gap, what);
    check(dec.res.size(), 2, "fire count");
  endtask

  task automatic pc(input iit_pkg::iit_desc_t d, input int c);
    pair(d, ia, c, "pc op spacing");
    check(dec.res[0].cycles, c, "pc op cycles");
    check(dec.res[0].dest_we, 0, "pc not scoreboarded");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_load_add();
    pair(ld, ia, 1, "load indep add");
    pair(ad, mk(iit_pkg::IIT_OP_DP, 4'h9, 4'h6, 4'h1, 4'h0), 1, "add add");
    check(dec.res[0].latency, 1, "add latency");
    pair(ld, mk(iit_pkg::IIT_OP_DP, 4'h6, 4'h5, 4'h1, 4'h0), 3, "load add");
    check(dec.res[0].latency, 3, "load latency");
    check(dec.res[0].dest, 1, "load dest");
    pair(ad, mk(iit_pkg::IIT_OP_WORD_LOAD, 4'h5, 4'h1, 4'h0, 4'h0), 2, "add base");
    pair(ld, mk(iit_pkg::IIT_OP_WORD_LOAD, 4'h5, 4'h1, 4'h0, 4'h0), 4, "load base");
  endtask

  task automatic t_shift();
    pair(ad, mk(iit_pkg::IIT_OP_DP_IMM_SHIFT, 4'h4, 4'h5, 4'h1, 4'h0), 2, "shifted");
    pair(ad, mk(iit_pkg::IIT_OP_DP_IMM_SHIFT, 4'h4, 4'h1, 4'h9, 4'h0), 1, "unshifted");
    pair(ad, mk(iit_pkg::IIT_OP_DP_REG_SHIFT, 4'h4, 4'h2, 4'h4, 4'h1), 2, "distance");
    pair(ld, mk(iit_pkg::IIT_OP_DP_REG_SHIFT, 4'h3, 4'h1, 4'h3, 4'h4), 2, "late");
    pair(mk(iit_pkg::IIT_OP_DP_REG_SHIFT, 4'h1, 4'h2, 4'h3, 4'h4), ia, 2, "busy");
    check(dec.res[0].cycles, 2, "reg shift cycles");
    check(dec.res[0].latency, 2, "reg shift latency");
  endtask

  task automatic t_sat_media();
    iit_pkg::iit_desc_t use1;
    use1 = mk(iit_pkg::IIT_OP_DP, 4'h6, 4'h1, 4'h5, 4'h0);
    pair(mk(iit_pkg::IIT_OP_SAT, 4'h1, 4'h2, 4'h3, 4'h0), use1, 2, "sat");
    pair(ad, mk(iit_pkg::IIT_OP_DSAT, 4'h4, 4'h1, 4'h5, 4'h0), 2, "dsat rn");
    pair(ad, mk(iit_pkg::IIT_OP_DSAT, 4'h4, 4'h5, 4'h1, 4'h0), 1, "dsat rm");
    pair(mk(iit_pkg::IIT_OP_MEDIA_ALU, 4'h1, 4'h2, 4'h3, 4'h0), use1, 1, "m alu");
    pair(mk(iit_pkg::IIT_OP_MEDIA_SAT, 4'h1, 4'h2, 4'h3, 4'h0), use1, 2, "m sat");
    pair(mk(iit_pkg::IIT_OP_MEDIA_SHIFT_SAT, 4'h1, 4'h2, 4'h3, 4'h0), use1, 2, "ms");
    pair(ad, mk(iit_pkg::IIT_OP_MEDIA_SHIFT_ALU, 4'h4, 4'h5, 4'h1, 4'h0), 2, "m sh");
    pair(ad, mk(iit_pkg::IIT_OP_MEDIA_ALU, 4'h4, 4'h5, 4'h1, 4'h0), 1, "m plain");
  endtask

  task automatic t_sad();
    iit_pkg::iit_desc_t sd;
    iit_pkg::iit_desc_t acc;
    sd = mk(iit_pkg::IIT_OP_SAD, 4'h1, 4'h0, 4'h2, 4'h3);
    acc = mk(iit_pkg::IIT_OP_SAD_ACC, 4'h7, 4'h0, 4'h4, 4'h5);
    acc.ra = '{1'b1, 4'h1};
    pair(sd, mk(iit_pkg::IIT_OP_DP, 4'h5, 4'h6, 4'h1, 4'h0), 3, "sad add");
    pair(sd, acc, 2, "sad acc");
    pair(ad, mk(iit_pkg::IIT_OP_SAD, 4'h4, 4'h0, 4'h1, 4'h5), 2, "sad early");
    play('{sd, mk(iit_pkg::IIT_OP_DP, 4'h9, 4'h9, 4'h0, 4'h0),
      mk(iit_pkg::IIT_OP_DP, 4'h9, 4'h9, 4'h0, 4'h0), mk(iit_pkg::IIT_OP_DP, 4'h5, 4'h6, 4'h1, 4'h0)});
    check(dec.takes[3] - dec.takes[0], 3, "sad fill");
  endtask

  task automatic t_pc();
    pc(mkpc(iit_pkg::IIT_OP_DP, 1, 1, iit_pkg::IIT_STACK_HIT, 0, 0), 4);
    pc(mkpc(iit_pkg::IIT_OP_DP, 1, 1, iit_pkg::IIT_STACK_MISS, 0, 0), 7);
    pc(mkpc(iit_pkg::IIT_OP_DP, 1, 1, iit_pkg::IIT_STACK_EMPTY, 0, 0), 5);
    pc(mkpc(iit_pkg::IIT_OP_DP, 1, 1, iit_pkg::IIT_STACK_HIT, 1, 1), 5);
    pc(mkpc(iit_pkg::IIT_OP_DP_IMM_SHIFT, 1, 0, iit_pkg::IIT_STACK_HIT, 1, 1), 6);
    pc(mkpc(iit_pkg::IIT_OP_DP, 1, 0, iit_pkg::IIT_STACK_HIT, 0, 0), 5);
    pc(mkpc(iit_pkg::IIT_OP_DP_IMM_SHIFT, 1, 0, iit_pkg::IIT_STACK_HIT, 0, 0), 6);
    pc(mkpc(iit_pkg::IIT_OP_DP_REG_SHIFT, 1, 0, iit_pkg::IIT_STACK_HIT, 0, 0), 7);
    pc(mkpc(iit_pkg::IIT_OP_DP, 0, 0, iit_pkg::IIT_STACK_HIT, 0, 0), 7);
    pc(mkpc(iit_pkg::IIT_OP_DP_REG_SHIFT, 0, 0, iit_pkg::IIT_STACK_HIT, 0, 0), 8);
    pc(mkpc(iit_pkg::IIT_OP_DP, 0, 0, iit_pkg::IIT_STACK_HIT, 1, 0), 1);
    pc(mkpc(iit_pkg::IIT_OP_DP_REG_SHIFT, 1, 0, iit_pkg::IIT_STACK_HIT, 1, 0), 2);
  endtask

  task automatic t_cond();
    iit_pkg::iit_desc_t s;
    iit_pkg::iit_desc_t c;
    s = ad;
    s.sets_flags = 1'b1;
    c = mkpc(iit_pkg::IIT_OP_DP, 1, 0, iit_pkg::IIT_STACK_HIT, 1, 1);
    play('{s, c});
    check(dec.res[1].cycles, 7, "cond gap 0");
    play('{s, ia, c});
    check(dec.res[2].cycles, 6, "cond gap 1");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    num_errors = 0;
    num_checks = 0;
    cycle_count = 0;
    ld = mk(iit_pkg::IIT_OP_WORD_LOAD, 4'h1, 4'h2, 4'h0, 4'h0);
    ad = mk(iit_pkg::IIT_OP_DP, 4'h1, 4'h2, 4'h3, 4'h0);
    ia = mk(iit_pkg::IIT_OP_DP, 4'h6, 4'h5, 4'h7, 4'h0);
    repeat (10) @(posedge core_clk);
    check(32'(issue_out), 0, "reset issue");
    rst <= 1'b0;
    @(posedge core_clk);
    t_load_add();
    t_shift();
    t_sat_media();
    t_sad();
    t_pc();
    t_cond();
    end_sim();
  end
endmodule

`default_nettype wire
